// ---- hdl/wait_state_and_reset_config.sv ----
`timescale 1ns/10ps
// Contract
// [R1] data wait field 00/01/10/11 adds 0/1/3/7 cycles per external data access
// [R2] new data wait value applies from the instruction after the writing one
// [R3] wide-bus member: data wait bits 9,8,1,0 not writable, read undefined
// [R4] other members: data wait bits 13-8 and 5-0 not writable, read undefined
// [R5] instruction wait bits 15-8 and 1-0 not writable, read undefined
// [R6] without external instruction bus, instruction wait register ignores writes
// [R7] instruction wait field offers 0/1/3/7 cycles per external fetch
// [R8] port command register answers at 0x3805 in X and Y spaces
// [R9] port command register resets to 0x0000
// [R10] both serial status registers reset to 0x0002
// [R11] host status register resets to 0x0301
// [R12] stored command with bit-manip enable drives selected port to set/clear bit
// [R13] host request mask bit holds its request output inactive high
module wait_state_and_reset_config #(
    parameter bit wide_bus = 1'b1,
    parameter int data_region_bits = 3,
    parameter int instr_region_bits = 2
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire wait_cfg_pkg::mem_req_type mem_req,
    output logic [15:0] mem_rdata,
    output logic mem_rvalid,
    input wire logic instr_boundary,
    input wire logic ext_data_req,
    input wire logic [data_region_bits-1:0] ext_data_region,
    output logic ext_data_ack,
    input wire logic ext_instr_req,
    input wire logic [instr_region_bits-1:0] ext_instr_region,
    output logic ext_instr_ack,
    input wire logic host_read_enable_set,
    input wire logic host_read_enable_clr,
    input wire logic host_write_enable_set,
    input wire logic host_write_enable_clr,
    input wire logic [3:0] host_err_set,
    output logic host_read_request_out_n,
    output logic host_write_request_out_n,
    output logic [wait_cfg_pkg::port_count-1:0] port_out,
    output logic [wait_cfg_pkg::port_count-1:0] port_oe
);

    localparam logic [15:0] data_wait_mask =
        wide_bus ? wait_cfg_pkg::data_wait_mask_wide : wait_cfg_pkg::data_wait_mask_narrow;

    logic [15:0] data_wait_cycle_reg_ff;
    logic [15:0] data_wait_active_ff;
    logic [15:0] instr_wait_cycle_reg_ff;
    logic [15:0] serial_status_reg_first_ff;
    logic [15:0] serial_status_reg_second_ff;
    logic [15:0] host_status_reg_ff;
    logic [wait_cfg_pkg::port_count-1:0] port_out_ff;
    logic [wait_cfg_pkg::port_count-1:0] port_dir_ff;
    logic [15:0] mem_rdata_ff;
    logic mem_rvalid_ff;
    logic [15:0] nxt_rdata;
    logic [15:0] nxt_host_status;
    logic [1:0] data_field;
    logic [1:0] instr_field;
    logic wr_port_cmd;
    logic wr_data_wait;
    logic wr_instr_wait;
    logic wr_ser_first;
    logic wr_ser_second;
    logic wr_host;
    logic [15:0] wd;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // the space select is not decoded, so X and Y both reach the same word
    assign wd = mem_req.wdata;
    assign wr_port_cmd = mem_req.wr && (mem_req.addr == wait_cfg_pkg::port_command_addr); // [R8]
    assign wr_data_wait = mem_req.wr && (mem_req.addr == wait_cfg_pkg::data_wait_addr);
    assign wr_instr_wait = mem_req.wr && (mem_req.addr == wait_cfg_pkg::instr_wait_addr);
    assign wr_ser_first = mem_req.wr && (mem_req.addr == wait_cfg_pkg::serial_status_first_addr);
    assign wr_ser_second = mem_req.wr && (mem_req.addr == wait_cfg_pkg::serial_status_second_addr);
    assign wr_host = mem_req.wr && (mem_req.addr == wait_cfg_pkg::host_status_addr);

    // ----------------------------------------
    // wait cycle registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            data_wait_cycle_reg_ff <= wait_cfg_pkg::data_wait_reset;
        end else if (wr_data_wait) begin
            data_wait_cycle_reg_ff <= wd & data_wait_mask; // [R3] [R4]
        end
    end

    // the copy that governs accesses moves only at an instruction boundary,
    // so the writing instruction itself still runs with the old setting
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            data_wait_active_ff <= wait_cfg_pkg::data_wait_reset;
        end else if (instr_boundary) begin
            data_wait_active_ff <= data_wait_cycle_reg_ff; // [R2]
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            instr_wait_cycle_reg_ff <= wait_cfg_pkg::instr_wait_reset;
        end else if (wr_instr_wait && wide_bus) begin
            instr_wait_cycle_reg_ff <= wd & wait_cfg_pkg::instr_wait_mask; // [R5] [R6]
        end
    end

    // ----------------------------------------
    // serial and host status
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            serial_status_reg_first_ff <= wait_cfg_pkg::serial_status_reset; // [R10]
        end else if (wr_ser_first) begin
            serial_status_reg_first_ff <= wd;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            serial_status_reg_second_ff <= wait_cfg_pkg::serial_status_reset; // [R10]
        end else if (wr_ser_second) begin
            serial_status_reg_second_ff <= wd;
        end
    end

    // error flags are sticky; a set in the clearing cycle wins
    always_comb begin
        nxt_host_status = host_status_reg_ff;
        if (wr_host) begin
            nxt_host_status = (host_status_reg_ff & ~wait_cfg_pkg::host_status_wr_mask)
                | (wd & wait_cfg_pkg::host_status_wr_mask);
        end
        nxt_host_status[wait_cfg_pkg::host_err_lo_pos +: 4] =
            nxt_host_status[wait_cfg_pkg::host_err_lo_pos +: 4] | host_err_set;
        if (host_read_enable_clr) begin
            nxt_host_status[wait_cfg_pkg::host_read_enable_pos] = 1'b0;
        end
        if (host_read_enable_set) begin
            nxt_host_status[wait_cfg_pkg::host_read_enable_pos] = 1'b1;
        end
        if (host_write_enable_clr) begin
            nxt_host_status[wait_cfg_pkg::host_write_enable_pos] = 1'b0;
        end
        if (host_write_enable_set) begin
            nxt_host_status[wait_cfg_pkg::host_write_enable_pos] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            host_status_reg_ff <= wait_cfg_pkg::host_status_reset; // [R11]
        end else begin
            host_status_reg_ff <= nxt_host_status;
        end
    end

    // outputs are active low; a set mask parks them high
    assign host_read_request_out_n =
        host_status_reg_ff[wait_cfg_pkg::host_read_request_mask_pos]
        || !host_status_reg_ff[wait_cfg_pkg::host_read_enable_pos]; // [R13]
    assign host_write_request_out_n =
        host_status_reg_ff[wait_cfg_pkg::host_write_request_mask_pos]
        || !host_status_reg_ff[wait_cfg_pkg::host_write_enable_pos]; // [R13]

    // ----------------------------------------
    // port command
    // ----------------------------------------
    // the command word is not stored and acts once; only its effect on the pins is kept, and a read returns the pin directions
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            port_out_ff <= '0; // [R9]
        end else if (wr_port_cmd && wd[wait_cfg_pkg::bit_manip_enable_pos]) begin
            port_out_ff[wd[wait_cfg_pkg::manip_port_select_pos +: 2]] <=
                wd[wait_cfg_pkg::port_set_clear_select_pos]; // [R12]
        end
    end

    // pins come out of reset as inputs
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            port_dir_ff <= '0; // [R9]
        end else if (wr_port_cmd && wd[wait_cfg_pkg::mode_enable_pos]) begin
            for (int i = 0; i < wait_cfg_pkg::port_count; i++) begin
                if (wd[i]) begin
                    port_dir_ff[i] <= wd[wait_cfg_pkg::mode_dir_pos];
                end
            end
        end
    end

    assign port_out = port_out_ff;
    assign port_oe = port_dir_ff;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // undefined bits read as zero here; software must not rely on that
    always_comb begin
        nxt_rdata = 16'h0000;
        unique case (mem_req.addr)
            wait_cfg_pkg::port_command_addr: nxt_rdata = {12'h000, port_dir_ff}; // [R8]
            wait_cfg_pkg::data_wait_addr: nxt_rdata = data_wait_cycle_reg_ff & data_wait_mask;
            wait_cfg_pkg::instr_wait_addr: nxt_rdata = instr_wait_cycle_reg_ff; // [R6]
            wait_cfg_pkg::serial_status_first_addr: nxt_rdata = serial_status_reg_first_ff;
            wait_cfg_pkg::serial_status_second_addr: nxt_rdata = serial_status_reg_second_ff;
            wait_cfg_pkg::host_status_addr: nxt_rdata = host_status_reg_ff;
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mem_rdata_ff <= 16'h0000;
            mem_rvalid_ff <= 1'b0;
        end else begin
            mem_rdata_ff <= mem_req.rd ? nxt_rdata : mem_rdata_ff;
            mem_rvalid_ff <= mem_req.rd;
        end
    end

    assign mem_rdata = mem_rdata_ff;
    assign mem_rvalid = mem_rvalid_ff;

    // ----------------------------------------
    // external access wait insertion
    // ----------------------------------------
    // each region owns the two-bit field at bit 2*region
    assign data_field = data_wait_active_ff[{ext_data_region, 1'b0} +: 2];
    assign instr_field = instr_wait_cycle_reg_ff[{ext_instr_region, 1'b0} +: 2];

    wait_sequencer data_wait_seq (
        .clock(clock),
        .reset_n(reset_n),
        .req(ext_data_req),
        .wait_cycles(wait_cfg_pkg::wait_count(data_field)), // [R1]
        .ack(ext_data_ack)
    );

    wait_sequencer instr_wait_seq (
        .clock(clock),
        .reset_n(reset_n),
        .req(ext_instr_req),
        .wait_cycles(wait_cfg_pkg::wait_count(instr_field)), // [R7]
        .ack(ext_instr_ack)
    );

endmodule : wait_state_and_reset_config

// ---- hdl/wait_cfg_pkg.sv ----
package wait_cfg_pkg;

    // ----------------------------------------
    // memory-mapped addresses
    // ----------------------------------------
    localparam logic [15:0] port_command_addr = 16'h3805;
    localparam logic [15:0] data_wait_addr = 16'h3806;
    localparam logic [15:0] instr_wait_addr = 16'h3807;
    localparam logic [15:0] serial_status_first_addr = 16'h3808;
    localparam logic [15:0] serial_status_second_addr = 16'h3809;
    localparam logic [15:0] host_status_addr = 16'h380a;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] port_command_reset = 16'h0000;
    localparam logic [15:0] serial_status_reset = 16'h0002;
    localparam logic [15:0] host_status_reset = 16'h0301;
    localparam logic [15:0] data_wait_reset = 16'h0000;
    localparam logic [15:0] instr_wait_reset = 16'h0000;

    // ----------------------------------------
    // writable bit masks
    // ----------------------------------------
    localparam logic [15:0] data_wait_mask_wide = 16'hfcfc;
    localparam logic [15:0] data_wait_mask_narrow = 16'hc0c0;
    localparam logic [15:0] instr_wait_mask = 16'h00fc;
    localparam logic [15:0] host_status_wr_mask = 16'h07fc;

    // ----------------------------------------
    // port command fields
    // ----------------------------------------
    localparam int bit_manip_enable_pos = 15;
    localparam int port_set_clear_select_pos = 14;
    localparam int mode_enable_pos = 13;
    localparam int mode_dir_pos = 12;
    localparam int manip_port_select_pos = 8;
    localparam int port_count = 4;

    // ----------------------------------------
    // host status fields
    // ----------------------------------------
    localparam int host_read_request_mask_pos = 9;
    localparam int host_write_request_mask_pos = 8;
    localparam int host_err_lo_pos = 2;
    localparam int host_read_enable_pos = 1;
    localparam int host_write_enable_pos = 0;

    localparam int wait_cnt_width = 3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_type;

    // two-bit setting to added cycles: 0, 1, 3, 7
    function automatic logic [wait_cnt_width-1:0] wait_count(input logic [1:0] field);
        unique case (field)
            2'b00: wait_count = 3'h0;
            2'b01: wait_count = 3'h1;
            2'b10: wait_count = 3'h3;
            2'b11: wait_count = 3'h7;
        endcase
    endfunction : wait_count

endpackage : wait_cfg_pkg

// ---- hdl/wait_sequencer.sv ----
`timescale 1ns/10ps
module wait_sequencer (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic req,
    input wire logic [wait_cfg_pkg::wait_cnt_width-1:0] wait_cycles,
    output logic ack
);

    logic [wait_cfg_pkg::wait_cnt_width-1:0] cnt_ff;

    // ----------------------------------------
    // counting
    // ----------------------------------------
    // ack is combinational so a zero-wait access completes in its own cycle
    assign ack = req && (cnt_ff == wait_cycles);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cnt_ff <= '0;
        end else if (!req || ack) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

endmodule : wait_sequencer

// ---- bench/wait_cfg_chk.sv ----
`timescale 1ns/10ps
module wait_cfg_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire wait_cfg_pkg::mem_req_type mem_req,
    input wire logic mem_rvalid,
    input wire logic ext_data_req,
    input wire logic ext_data_ack,
    input wire logic ext_instr_req,
    input wire logic ext_instr_ack,
    input wire logic host_read_request_out_n,
    input wire logic host_write_request_out_n,
    input wire logic [wait_cfg_pkg::port_count-1:0] port_out,
    input wire logic [wait_cfg_pkg::port_count-1:0] port_oe
);
    default clocking @(posedge clock); endclocking
    // mirror of the two request masks, so the outputs can be tied to them
    logic [1:0] mask_ff;
    logic [1:0] nxt_mask;
    logic host_wr;
    logic port_wr;
    assign host_wr = mem_req.wr && mem_req.addr == wait_cfg_pkg::host_status_addr;
    assign port_wr = mem_req.wr && mem_req.addr == wait_cfg_pkg::port_command_addr;
    assign nxt_mask = host_wr ? mem_req.wdata[9:8] : mask_ff;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mask_ff <= 2'h3;
        end else begin
            mask_ff <= nxt_mask;
        end
    end
    AST_RVALID: assert property (disable iff (!reset_n) mem_req.rd |=> mem_rvalid)
        else $error("read not answered");
    AST_NO_RVALID: assert property (disable iff (!reset_n) !mem_req.rd |=> !mem_rvalid)
        else $error("read answer without read");
    AST_READ_REQ_MASK: assert property (disable iff (!reset_n)
        mask_ff[1] |-> host_read_request_out_n)
        else $error("masked read request active");
    AST_WRITE_REQ_MASK: assert property (disable iff (!reset_n)
        mask_ff[0] |-> host_write_request_out_n)
        else $error("masked write request active");
    AST_RST_PORT: assert property (disable iff (1'b0)
        !reset_n |=> port_out == 4'h0 && port_oe == 4'h0)
        else $error("port not cleared by reset");
    AST_RST_HOST: assert property (disable iff (1'b0)
        !reset_n |=> host_read_request_out_n && host_write_request_out_n)
        else $error("host requests not inactive after reset");
    AST_PORT_SET: assert property (disable iff (!reset_n)
        port_wr && mem_req.wdata[15] |=>
        port_out[$past(mem_req.wdata[9:8])] == $past(mem_req.wdata[14]))
        else $error("selected port level wrong");
    AST_DATA_ACK: assert property (disable iff (!reset_n)
        $rose(ext_data_req) |-> ##[0:7] ext_data_ack)
        else $error("data access wait too long");
    AST_INSTR_ACK: assert property (disable iff (!reset_n)
        $rose(ext_instr_req) |-> ##[0:7] ext_instr_ack)
        else $error("fetch wait too long");
endmodule : wait_cfg_chk
bind wait_state_and_reset_config wait_cfg_chk i_wait_cfg_chk (.clock(clock), .reset_n(reset_n),
    .mem_req(mem_req), .mem_rvalid(mem_rvalid), .ext_data_req(ext_data_req),
    .ext_data_ack(ext_data_ack), .ext_instr_req(ext_instr_req), .ext_instr_ack(ext_instr_ack),
    .host_read_request_out_n(host_read_request_out_n),
    .host_write_request_out_n(host_write_request_out_n), .port_out(port_out), .port_oe(port_oe));

// ---- bench/ext_mem_model.sv ----
`timescale 1ns/10ps
module ext_mem_model (
    input wire logic clock,
    input wire logic req,
    input wire logic ack,
    output int wait_seen
);
    // slow memory: counts the wait cycles it was granted before completion
    int count_ff = 0;
    always @(posedge clock) begin
        if (req && ack) begin
            wait_seen <= count_ff;
            count_ff <= 0;
        end else if (req) begin
            count_ff <= count_ff + 1;
        end
    end
endmodule : ext_mem_model

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic clock;
    logic reset_n;
    wait_cfg_pkg::mem_req_type mem_req;
    logic [15:0] mem_rdata;
    logic [15:0] narrow_rdata;
    logic [2:0] data_region;
    logic [1:0] instr_region;
    logic mem_rvalid, instr_boundary, ext_data_req, ext_data_ack, ext_instr_req, ext_instr_ack;
    logic rd_set, rd_clr, wr_set, wr_clr, req_rd_n, req_wr_n;
    logic [3:0] host_err_set, port_out, port_oe;
    int data_seen, instr_seen, mismatches, checks_done, cycles;
    int waits[4] = '{0, 1, 3, 7};
    wait_state_and_reset_config i_wait_state_and_reset_config (.clock(clock), .reset_n(reset_n),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .instr_boundary(instr_boundary), .ext_data_req(ext_data_req),
        .ext_data_region(data_region), .ext_data_ack(ext_data_ack),
        .ext_instr_req(ext_instr_req), .ext_instr_region(instr_region),
        .ext_instr_ack(ext_instr_ack), .host_read_enable_set(rd_set),
        .host_read_enable_clr(rd_clr), .host_write_enable_set(wr_set),
        .host_write_enable_clr(wr_clr), .host_err_set(host_err_set),
        .host_read_request_out_n(req_rd_n), .host_write_request_out_n(req_wr_n),
        .port_out(port_out), .port_oe(port_oe));
    // narrow-bus member: its read data is compared, the rest is left to the checker
    wait_state_and_reset_config #(.wide_bus(1'b0)) i_wait_state_and_reset_config_narrow (
        .clock(clock), .reset_n(reset_n), .mem_req(mem_req), .mem_rdata(narrow_rdata),
        .mem_rvalid(), .instr_boundary(instr_boundary), .ext_data_req(ext_data_req),
        .ext_data_region(data_region), .ext_data_ack(), .ext_instr_req(ext_instr_req),
        .ext_instr_region(instr_region), .ext_instr_ack(), .host_read_enable_set(rd_set),
        .host_read_enable_clr(rd_clr), .host_write_enable_set(wr_set),
        .host_write_enable_clr(wr_clr), .host_err_set(host_err_set),
        .host_read_request_out_n(), .host_write_request_out_n(), .port_out(), .port_oe());
    ext_mem_model i_data_mem (.clock(clock), .req(ext_data_req), .ack(ext_data_ack),
        .wait_seen(data_seen));
    ext_mem_model i_instr_mem (.clock(clock), .req(ext_instr_req), .ack(ext_instr_ack),
        .wait_seen(instr_seen));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_wr(input logic [15:0] addr, input logic [15:0] data);
        @(posedge clock) #1;
        mem_req.wr = 1'b1;
        mem_req.addr = addr;
        mem_req.wdata = data;
        @(posedge clock) #1;
        mem_req.wr = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [15:0] addr, input logic [15:0] exp, input string what);
        @(posedge clock) #1;
        mem_req.rd = 1'b1;
        mem_req.addr = addr;
        @(posedge clock) #1;
        mem_req.rd = 1'b0;
        check("read valid", {15'h0, mem_rvalid}, 16'h1);
        check(what, mem_rdata, exp);
    endtask : reg_rd
    task automatic pulse_boundary;
        @(posedge clock) #1;
        instr_boundary = 1'b1;
        @(posedge clock) #1;
        instr_boundary = 1'b0;
    endtask : pulse_boundary
    // waits for the handshake, then compares the waits the memory saw
    task automatic access(input bit instr, input int exp);
        int n;
        n = 0;
        @(posedge clock) #1;
        if (instr) ext_instr_req = 1'b1;
        else ext_data_req = 1'b1;
        while ((instr ? ext_instr_ack : ext_data_ack) !== 1'b1 && n < 20) begin
            @(posedge clock) #1;
            n++;
        end
        check("access ack", {15'h0, instr ? ext_instr_ack : ext_data_ack}, 16'h1);
        @(posedge clock) #1;
        ext_instr_req = 1'b0;
        ext_data_req = 1'b0;
        check("wait cycles", 16'(instr ? instr_seen : data_seen), 16'(exp));
    endtask : access
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        reg_rd(wait_cfg_pkg::port_command_addr, 16'h0000, "port command");
        reg_rd(wait_cfg_pkg::serial_status_first_addr, 16'h0002, "serial first");
        reg_rd(wait_cfg_pkg::serial_status_second_addr, 16'h0002, "serial second");
        reg_rd(wait_cfg_pkg::host_status_addr, 16'h0301, "host status");
        reg_rd(16'h3810, 16'h0000, "unmapped");
        check("requests idle", {14'h0, req_rd_n, req_wr_n}, 16'h3);
        $display("reset test done");
    endtask : test_reset
    task automatic test_waits;
        for (int f = 0; f < 4; f++) begin
            reg_wr(wait_cfg_pkg::data_wait_addr, 16'(f << 2));
            reg_wr(wait_cfg_pkg::instr_wait_addr, 16'(f << 2));
            pulse_boundary();
            access(1'b0, waits[f]);
            access(1'b1, waits[f]);
        end
        // a new setting must not act before the next instruction begins
        reg_wr(wait_cfg_pkg::data_wait_addr, 16'h0004);
        access(1'b0, 7);
        pulse_boundary();
        access(1'b0, 1);
        reg_wr(wait_cfg_pkg::data_wait_addr, 16'hffff);
        reg_rd(wait_cfg_pkg::data_wait_addr, 16'hfcfc, "data wait bits");
        check("narrow data wait bits", narrow_rdata, 16'hc0c0);
        reg_wr(wait_cfg_pkg::instr_wait_addr, 16'hffff);
        reg_rd(wait_cfg_pkg::instr_wait_addr, 16'h00fc, "instr wait bits");
        check("narrow instr wait", narrow_rdata, 16'h0000);
        // other regions pick other fields
        reg_wr(wait_cfg_pkg::data_wait_addr, 16'h4000);
        reg_wr(wait_cfg_pkg::instr_wait_addr, 16'h0080);
        pulse_boundary();
        data_region = 3'h7;
        instr_region = 2'h3;
        access(1'b0, 1);
        access(1'b1, 3);
        $display("wait test done");
    endtask : test_waits
    task automatic test_port;
        for (int p = 0; p < 4; p++) begin
            reg_wr(wait_cfg_pkg::port_command_addr, 16'hc000 | 16'(p << 8));
            check("port set", {15'h0, port_out[p]}, 16'h1);
            reg_wr(wait_cfg_pkg::port_command_addr, 16'h8000 | 16'(p << 8));
            check("port clear", {15'h0, port_out[p]}, 16'h0);
        end
        reg_wr(wait_cfg_pkg::port_command_addr, 16'h300f);
        check("port dir", {12'h0, port_oe}, 16'h000f);
        reg_rd(wait_cfg_pkg::port_command_addr, 16'h000f, "port dir read");
        reg_wr(wait_cfg_pkg::port_command_addr, 16'h2005);
        check("port dir input", {12'h0, port_oe}, 16'h000a);
        $display("port test done");
    endtask : test_port
    task automatic test_host;
        reg_wr(wait_cfg_pkg::host_status_addr, 16'h0000);
        check("unmasked requests", {14'h0, req_rd_n, req_wr_n}, 16'h2);
        @(posedge clock) #1;
        rd_set = 1'b1;
        wr_clr = 1'b1;
        host_err_set = 4'hf;
        @(posedge clock) #1;
        rd_set = 1'b0;
        wr_clr = 1'b0;
        host_err_set = 4'h0;
        check("read request", {14'h0, req_rd_n, req_wr_n}, 16'h1);
        reg_rd(wait_cfg_pkg::host_status_addr, 16'h003e, "host flags");
        // a set and a clear of one flag in the same cycle: the set wins
        @(posedge clock) #1;
        rd_clr = 1'b1;
        wr_set = 1'b1;
        wr_clr = 1'b1;
        @(posedge clock) #1;
        {rd_clr, wr_set, wr_clr} = 3'h0;
        check("set over clear", {14'h0, req_rd_n, req_wr_n}, 16'h2);
        reg_wr(wait_cfg_pkg::host_status_addr, 16'h0300);
        check("masked requests", {14'h0, req_rd_n, req_wr_n}, 16'h3);
        reg_rd(wait_cfg_pkg::host_status_addr, 16'h0301, "host after write");
        $display("host test done");
    endtask : test_host
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        reset_n = 1'b0;
        mem_req = '0;
        {instr_boundary, ext_data_req, ext_instr_req, rd_set, rd_clr, wr_set, wr_clr} = '0;
        host_err_set = 4'h0;
        data_region = 3'h1;
        instr_region = 2'h1;
        repeat (5) @(posedge clock);
        #1 reset_n = 1'b1;
        test_reset();
        test_waits();
        test_port();
        test_host();
        close_out();
    end
endmodule : testbench
